// *** logic/flash_host_pkg.sv ***
//------------------------------------------------------------------
//------------------------------------------------------------------
package flash_host_pkg;

	//------------------------------------------------------------
	// Timing
	//------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int SETUP_NS = 10;
	localparam int WE_LOW_NS = 20;
	localparam int HOLD_NS = 20;
	localparam int RE_LOW_NS = 60;
	localparam int RE_HIGH_NS = 20;
	localparam int PROTECT_SETTLE_NS = 100;
	localparam int RB_GUARD_NS = 200;
	localparam int RESET_BUSY_NS = 1000000;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		if (c < 1) c = 1;
		return c;
	endfunction : ns_to_cyc

	localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
	localparam int WE_LOW_CYC = ns_to_cyc(WE_LOW_NS);
	localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
	localparam int RE_LOW_CYC = ns_to_cyc(RE_LOW_NS);
	localparam int RE_HIGH_CYC = ns_to_cyc(RE_HIGH_NS);
	localparam int SETTLE_CYC = ns_to_cyc(PROTECT_SETTLE_NS);
	localparam int RB_GUARD_CYC = ns_to_cyc(RB_GUARD_NS);
	localparam int RESET_BUSY_DEF = RESET_BUSY_NS / CLK_NS;

	// Timer loads: a phase lasts load + 1 cycles
	localparam logic [19:0] SETUP_LD = 20'(SETUP_CYC - 1);
	localparam logic [19:0] WE_LOW_LD = 20'(WE_LOW_CYC - 1);
	localparam logic [19:0] HOLD_LD = 20'(HOLD_CYC - 1);
	localparam logic [19:0] RE_LOW_LD = 20'(RE_LOW_CYC - 1);
	localparam logic [19:0] RE_HIGH_LD = 20'(RE_HIGH_CYC - 1);
	localparam logic [19:0] SETTLE_LD = 20'(SETTLE_CYC - 1);
	localparam logic [19:0] RB_GUARD_LD = 20'(RB_GUARD_CYC - 1);

	//------------------------------------------------------------
	// Register map and fields
	//------------------------------------------------------------
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_READ = 8'h0C;
	localparam logic [7:0] OFS_COL = 8'h10;
	localparam logic [7:0] OFS_ROW = 8'h14;
	localparam logic [7:0] OFS_ADDR5 = 8'h18;
	localparam logic [7:0] OFS_CTRL = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam int CTRL_SEL_BIT = 0;
	localparam int CTRL_PROT_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RDY_BIT = 1;
	localparam int ST_INIT_BIT = 2;
	localparam int ST_ERR_BIT = 3;
	localparam int ST_ENH_BIT = 4;
	localparam int PLANE_BIT = 6;
	localparam logic [2:0] LAST_ADDR_IDX = 3'h4;

	//------------------------------------------------------------
	// Command bytes
	//------------------------------------------------------------
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_STATUS_DIE = 8'h78;
	localparam logic [7:0] CMD_READ_MODE = 8'h00;

	//------------------------------------------------------------
	// Types
	//------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_STROBE = 6'h04,
		ST_HOLD = 6'h08,
		ST_SETTLE = 6'h10,
		ST_WAITRDY = 6'h20
	} state_t;

	typedef enum logic [1:0] {
		OP_CMD = 2'h0,
		OP_ADDR = 2'h1,
		OP_DIN = 2'h2,
		OP_DOUT = 2'h3
	} op_t;

	typedef struct packed {
		logic select_n;
		logic cmd_latch_en;
		logic addr_latch_en;
		logic write_strobe_n;
		logic read_strobe_n;
		logic protect_n;
	} ctl_pins_t;

	localparam ctl_pins_t CTL_RESET = '{select_n: 1'b1,
		cmd_latch_en: 1'b0, addr_latch_en: 1'b0, write_strobe_n: 1'b1,
		read_strobe_n: 1'b1, protect_n: 1'b0};

endpackage : flash_host_pkg

// *** logic/flash_pin_sync.sv ***
`timescale 1ns/1ns
module flash_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_reg, s1_next, s2_reg, s2_next;
	logic [W-1:0] s3_reg, s3_next, lvl_reg, lvl_next;

	// Three stages; a change counts when stages two and three agree
	always_comb begin
		s1_next = pin;
		s2_next = s1_reg;
		s3_next = s2_reg;
		lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			lvl_reg <= lvl_next;
		end
	end

	assign level = lvl_reg;
endmodule : flash_pin_sync

// *** logic/flash_wait_timer.sv ***
`timescale 1ns/1ns
module flash_wait_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [19:0] load_val,
	output logic done
);
	logic [19:0] cnt_reg, cnt_next;

	// Down counter; done while it rests at zero
	always_comb begin
		if (load) cnt_next = load_val;
		else if (cnt_reg != 20'h00000) cnt_next = cnt_reg - 20'h00001;
		else cnt_next = cnt_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) cnt_reg <= 20'h00000;
		else cnt_reg <= cnt_next;
	end

	assign done = (cnt_reg == 20'h00000);
endmodule : flash_wait_timer

// *** logic/flash_host_ctrl.sv ***
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module flash_host_ctrl #(
	parameter int RESET_BUSY_CYC = flash_host_pkg::RESET_BUSY_DEF
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output flash_host_pkg::ctl_pins_t CTL,
	input wire logic [15:0] DQ_IN,
	output logic [15:0] DQ_OUT,
	output logic DQ_OE,
	input wire logic RB_N_IN
);
	import flash_host_pkg::*;

	//------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------
	state_t state_reg, state_next;
	op_t op_reg, op_next;
	ctl_pins_t pins_reg, pins_next;
	logic [15:0] dq_reg, dq_next;
	logic oe_reg, oe_next;
	logic [2:0] burst_reg, burst_next;
	logic bst_reg, bst_next;
	logic [15:0] rdw_reg, rdw_next;
	logic init_reg, init_next;
	logic seq_reg, seq_next;
	logic enh_reg, enh_next;
	logic guard_reg, guard_next;
	logic [7:0] lcmd_reg, lcmd_next;
	logic [10:0] col_reg, col_next;
	logic [16:0] row_reg, row_next;
	logic sel_reg, sel_next;
	logic preq_reg, preq_next;
	logic err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [19:0] tmr_val;
	logic tmr_load, tmr_done;
	logic eng_err;
	logic [15:0] dq_sync;
	logic rb_sync;
	logic wr_cmd, wr_adr, wr_dat, wr_rdq, wr_a5, issue;
	logic idle, prot_pend, legal, refuse, stat_cmd;
	logic [31:0] status_w;

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Address byte of a five-cycle burst
	function automatic logic [7:0] addr_byte(input logic [2:0] idx,
		input logic [10:0] col, input logic [16:0] row);
		logic [10:0] c;
		c = col;
		if (c[10]) c[9:5] = 5'h00;
		case (idx)
		3'h0: addr_byte = c[7:0];
		3'h1: addr_byte = {5'h00, c[10:8]};
		3'h2: addr_byte = row[7:0]; // row bit PLANE_BIT selects plane
		3'h3: addr_byte = row[15:8];
		default: addr_byte = {7'h00, row[16]};
		endcase
	endfunction : addr_byte

	//------------------------------------------------------------
	// Pin inputs and phase timer
	//------------------------------------------------------------
	flash_pin_sync #(.W(16)) u_dq_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.pin(DQ_IN),
		.level(dq_sync)
	);

	flash_pin_sync #(.W(1)) u_rb_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.pin(RB_N_IN),
		.level(rb_sync)
	);

	flash_wait_timer u_timer (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	//------------------------------------------------------------
	// Request decode and acceptance
	//------------------------------------------------------------
	// Writes that start a bus cycle
	assign wr_cmd = WR && (ADDR == OFS_CMD);
	assign wr_adr = WR && (ADDR == OFS_ADDR);
	assign wr_dat = WR && (ADDR == OFS_DATA);
	assign wr_rdq = WR && (ADDR == OFS_READ);
	assign wr_a5 = WR && (ADDR == OFS_ADDR5);
	assign issue = wr_cmd | wr_adr | wr_dat | wr_rdq | wr_a5;
	assign idle = (state_reg == ST_IDLE);
	assign prot_pend = (preq_reg != pins_reg.protect_n);
	assign stat_cmd = (lcmd_reg == CMD_STATUS) ||
		(lcmd_reg == CMD_STATUS_DIE);

	// A request is taken only when idle, selected and not settling
	always_comb begin
		legal = 1'b0;
		if (idle && !prot_pend && sel_reg) begin
			if (wr_cmd)
				legal = init_reg || (WDATA[7:0] == CMD_RESET);
			else if (wr_adr || wr_a5 || wr_dat)
				legal = init_reg && seq_reg;
			else if (wr_rdq)
				legal = init_reg && seq_reg && (!enh_reg || stat_cmd);
		end
	end
	assign refuse = issue && !legal;

	//------------------------------------------------------------
	// Bus cycle engine
	//------------------------------------------------------------
	// Next state of the pin sequencer
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		pins_next = pins_reg;
		dq_next = dq_reg;
		oe_next = oe_reg;
		burst_next = burst_reg;
		bst_next = bst_reg;
		rdw_next = rdw_reg;
		init_next = init_reg;
		seq_next = seq_reg;
		enh_next = enh_reg;
		guard_next = guard_reg;
		lcmd_next = lcmd_reg;
		tmr_load = 1'b0;
		tmr_val = 20'h00000;
		eng_err = 1'b0;
		case (state_reg)
		ST_IDLE: begin
			pins_next.select_n = ~sel_reg;
			if (issue && legal) begin
				tmr_load = 1'b1;
				tmr_val = SETUP_LD;
				state_next = ST_SETUP;
				oe_next = 1'b1;
				bst_next = wr_a5;
				burst_next = 3'h0;
				pins_next.cmd_latch_en = wr_cmd;
				pins_next.addr_latch_en = wr_adr | wr_a5;
				dq_next = {8'h00, WDATA[7:0]};
				if (wr_cmd) begin
					op_next = OP_CMD;
					seq_next = 1'b1;
					lcmd_next = WDATA[7:0];
					if (WDATA[7:0] == CMD_STATUS_DIE) enh_next = 1'b1;
					if (WDATA[7:0] == CMD_READ_MODE) enh_next = 1'b0;
				end else if (wr_a5) begin
					op_next = OP_ADDR;
					dq_next = {8'h00, addr_byte(3'h0, col_reg, row_reg)};
				end else if (wr_adr) begin
					op_next = OP_ADDR;
				end else if (wr_dat) begin
					op_next = OP_DIN;
					dq_next = WDATA[15:0];
				end else begin
					op_next = OP_DOUT;
					oe_next = 1'b0;
				end
			end else if (prot_pend && rb_sync) begin
				pins_next.protect_n = preq_reg;
				tmr_load = 1'b1;
				tmr_val = SETTLE_LD;
				state_next = ST_SETTLE;
			end
		end
		ST_SETUP: begin
			if (tmr_done) begin
				tmr_load = 1'b1;
				state_next = ST_STROBE;
				if (op_reg == OP_DOUT) begin
					pins_next.read_strobe_n = 1'b0;
					tmr_val = RE_LOW_LD;
				end else begin
					pins_next.write_strobe_n = 1'b0;
					tmr_val = WE_LOW_LD;
				end
			end
		end
		ST_STROBE: begin
			if (tmr_done) begin
				pins_next.write_strobe_n = 1'b1;
				pins_next.read_strobe_n = 1'b1;
				tmr_load = 1'b1;
				state_next = ST_HOLD;
				if (op_reg == OP_DOUT) begin
					rdw_next = dq_sync;
					tmr_val = RE_HIGH_LD;
				end else begin
					tmr_val = HOLD_LD;
				end
			end
		end
		ST_HOLD: begin
			if (tmr_done) begin
				if (bst_reg && (burst_reg != LAST_ADDR_IDX)) begin
					burst_next = burst_reg + 3'h1;
					dq_next = {8'h00,
						addr_byte(burst_reg + 3'h1, col_reg, row_reg)};
					tmr_load = 1'b1;
					tmr_val = SETUP_LD;
					state_next = ST_SETUP;
				end else begin
					pins_next.cmd_latch_en = 1'b0;
					pins_next.addr_latch_en = 1'b0;
					oe_next = 1'b0;
					bst_next = 1'b0;
					if ((op_reg == OP_CMD) && (dq_reg[7:0] == CMD_RESET)) begin
						init_next = 1'b0;
						guard_next = 1'b0;
						tmr_load = 1'b1;
						tmr_val = RB_GUARD_LD;
						state_next = ST_WAITRDY;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
		end
		ST_WAITRDY: begin
			// Guard lets the ready line fall before it is watched
			if (!guard_reg) begin
				if (tmr_done) begin
					guard_next = 1'b1;
					tmr_load = 1'b1;
					tmr_val = 20'(RESET_BUSY_CYC - 1);
				end
			end else if (rb_sync) begin
				init_next = 1'b1;
				state_next = ST_IDLE;
			end else if (tmr_done) begin
				eng_err = 1'b1;
				state_next = ST_IDLE;
			end
		end
		ST_SETTLE: begin
			if (tmr_done) state_next = ST_IDLE;
		end
		default: begin
			state_next = ST_IDLE;
			pins_next = CTL_RESET;
			oe_next = 1'b0;
		end
		endcase
	end

	// Engine registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_CMD;
			pins_reg <= CTL_RESET;
			dq_reg <= 16'h0000;
			oe_reg <= 1'b0;
			burst_reg <= 3'h0;
			bst_reg <= 1'b0;
			rdw_reg <= 16'h0000;
			init_reg <= 1'b0;
			seq_reg <= 1'b0;
			enh_reg <= 1'b0;
			guard_reg <= 1'b0;
			lcmd_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			pins_reg <= pins_next;
			dq_reg <= dq_next;
			oe_reg <= oe_next;
			burst_reg <= burst_next;
			bst_reg <= bst_next;
			rdw_reg <= rdw_next;
			init_reg <= init_next;
			seq_reg <= seq_next;
			enh_reg <= enh_next;
			guard_reg <= guard_next;
			lcmd_reg <= lcmd_next;
		end
	end

	//------------------------------------------------------------
	// Software registers
	//------------------------------------------------------------
	// Status word assembly
	always_comb begin
		status_w = 32'h00000000;
		status_w[ST_BUSY_BIT] = !idle;
		status_w[ST_RDY_BIT] = rb_sync;
		status_w[ST_INIT_BIT] = init_reg;
		status_w[ST_ERR_BIT] = err_reg;
		status_w[ST_ENH_BIT] = enh_reg;
	end

	// Writes, error flag and read data
	always_comb begin
		col_next = col_reg;
		row_next = row_reg;
		sel_next = sel_reg;
		preq_next = preq_reg;
		if (WR && (ADDR == OFS_COL)) col_next = WDATA[10:0];
		if (WR && (ADDR == OFS_ROW)) row_next = WDATA[16:0];
		if (WR && (ADDR == OFS_CTRL)) begin
			sel_next = WDATA[CTRL_SEL_BIT];
			preq_next = WDATA[CTRL_PROT_BIT];
		end
		// Set wins over the write-one clear
		err_next = (err_reg &
			!(WR && (ADDR == OFS_STATUS) && WDATA[ST_ERR_BIT])) |
			refuse | eng_err;
		rdata_next = 32'h00000000;
		if (RD) begin
			case (ADDR)
			OFS_DATA: rdata_next = {16'h0000, rdw_reg};
			OFS_COL: rdata_next = {21'h000000, col_reg};
			OFS_ROW: rdata_next = {15'h0000, row_reg};
			OFS_CTRL: rdata_next = {30'h00000000, preq_reg, sel_reg};
			OFS_STATUS: rdata_next = status_w;
			default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			col_reg <= 11'h000;
			row_reg <= 17'h00000;
			sel_reg <= 1'b0;
			preq_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			col_reg <= col_next;
			row_reg <= row_next;
			sel_reg <= sel_next;
			preq_reg <= preq_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA = rdata_reg;
	assign CTL = pins_reg;
	assign DQ_OUT = dq_reg;
	assign DQ_OE = oe_reg;

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	property p_no_dual_latch;
		@(posedge SYS_CLK) disable iff (!RST_N)
		!(CTL.cmd_latch_en && CTL.addr_latch_en);
	endproperty
	a_no_dual_latch: assert property (p_no_dual_latch)
		else $error("both latch enables high");

	property p_cmd_edge;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(CTL.write_strobe_n) && CTL.cmd_latch_en |->
			!CTL.select_n && !CTL.addr_latch_en && CTL.read_strobe_n
			&& DQ_OE && (DQ_OUT[15:8] == 8'h00);
	endproperty
	a_cmd_edge: assert property (p_cmd_edge)
		else $error("bad pins at command strobe");

	property p_addr_edge;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(CTL.write_strobe_n) && CTL.addr_latch_en |->
			!CTL.select_n && !CTL.cmd_latch_en && CTL.read_strobe_n
			&& (DQ_OUT[15:8] == 8'h00);
	endproperty
	a_addr_edge: assert property (p_addr_edge)
		else $error("bad pins at address strobe");

	property p_data_edge;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(CTL.write_strobe_n) && !CTL.cmd_latch_en &&
			!CTL.addr_latch_en |->
			!CTL.select_n && CTL.read_strobe_n && DQ_OE;
	endproperty
	a_data_edge: assert property (p_data_edge)
		else $error("bad pins at data strobe");

	property p_read_low;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$fell(CTL.read_strobe_n) |-> (!CTL.read_strobe_n && !DQ_OE &&
			CTL.write_strobe_n)[*6] ##1 CTL.read_strobe_n;
	endproperty
	a_read_low: assert property (p_read_low)
		else $error("read strobe low time wrong");

	property p_prot_settle;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$changed(CTL.protect_n) |-> ($past(state_reg) == ST_IDLE
			&& $past(rb_sync)) ##0 (state_reg == ST_SETTLE &&
			CTL.write_strobe_n)[*8];
	endproperty
	a_prot_settle: assert property (p_prot_settle)
		else $error("protect change not settled");

	property p_first_reset;
		@(posedge SYS_CLK) disable iff (!RST_N)
		CTL.cmd_latch_en && !init_reg |-> DQ_OUT[7:0] == CMD_RESET;
	endproperty
	a_first_reset: assert property (p_first_reset)
		else $error("command before reset done");

	property p_addr_after_cmd;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(CTL.addr_latch_en) |-> seq_reg && init_reg;
	endproperty
	a_addr_after_cmd: assert property (p_addr_after_cmd)
		else $error("address without command");

	property p_addr_layout;
		@(posedge SYS_CLK) disable iff (!RST_N)
		bst_reg && CTL.addr_latch_en && (burst_reg == 3'h1) |->
			DQ_OUT[7:3] == 5'h00;
	endproperty
	a_addr_layout: assert property (p_addr_layout)
		else $error("column high byte layout");

	property p_col_mask;
		@(posedge SYS_CLK) disable iff (!RST_N)
		bst_reg && CTL.addr_latch_en && (burst_reg == 3'h0) &&
			col_reg[10] |-> DQ_OUT[7:5] == 3'h0;
	endproperty
	a_col_mask: assert property (p_col_mask)
		else $error("column bits not masked");
endmodule : flash_host_ctrl

// *** bench/flash_dev_model.sv ***
`timescale 1ns/1ns
module flash_dev_model #(
	parameter int BUSY_NS = 1000
) (
	input wire flash_host_pkg::ctl_pins_t ctl,
	input wire logic [15:0] dq,
	output logic [15:0] dq_drv,
	output logic rb_low
);
	import flash_host_pkg::*;
	//------------------------------------------------------------
	// Die state
	//------------------------------------------------------------
	logic busy = 1'b0;
	logic enh = 1'b0;
	logic plane = 1'b0;
	logic hi_bad = 1'b0;
	logic [7:0] cmd_reg = 8'h00;
	logic [39:0] addr_sh = 40'h0;
	logic [15:0] din_reg = 16'h0000;
	logic [7:0] status;
	int addr_n = 0;
	int cmd_cnt = 0;
	// Open-drain ready line pulls low while the die works
	assign rb_low = busy;
	// Own status byte: protect pin level and ready flag
	assign status = {ctl.protect_n, ~busy, 6'h00};
	initial dq_drv = 16'h5A5A;
	// Latch on write strobe rise; both latch enables high is void
	always @(posedge ctl.write_strobe_n) begin
		if (!ctl.select_n && ctl.read_strobe_n) begin
			if (ctl.cmd_latch_en && !ctl.addr_latch_en) begin
				if (dq[15:8] !== 8'h00) hi_bad = 1'b1;
				if (!busy || dq[7:0] inside {8'h70, 8'h78, 8'hFF}) begin
					cmd_reg = dq[7:0];
					cmd_cnt++;
					addr_n = 0;
					enh = (dq[7:0] == CMD_STATUS_DIE);
				end
				if (dq[7:0] == CMD_RESET) begin
					busy = 1'b1;
					busy <= #(BUSY_NS) 1'b0;
				end
			end else if (ctl.addr_latch_en && !ctl.cmd_latch_en) begin
				if (dq[15:8] !== 8'h00) hi_bad = 1'b1;
				if (!busy || enh) begin
					addr_sh = {dq[7:0], addr_sh[39:8]};
					if (addr_n == 2) plane = dq[6];
					addr_n++;
				end
			end else if (!ctl.cmd_latch_en && !ctl.addr_latch_en && !busy) begin
				din_reg = dq;
			end
		end
	end
	// Output on read strobe fall; busy die answers with status only
	always @(negedge ctl.read_strobe_n) begin
		if (!ctl.select_n && !ctl.cmd_latch_en && !ctl.addr_latch_en
			&& ctl.write_strobe_n) begin
			if (cmd_reg == CMD_STATUS || cmd_reg == CMD_STATUS_DIE) begin
				dq_drv = {8'h00, status};
			end else if (!busy) begin
				dq_drv = din_reg;
			end
		end
	end
	// Released or deselected bus shows the inverse of the last word
	always @(posedge ctl.select_n) dq_drv = ~dq_drv;
	always @(posedge ctl.read_strobe_n) dq_drv <= #10 ~dq_drv;
endmodule : flash_dev_model

// *** bench/nand_async_bus_interface_test.sv ***
`timescale 1ns/1ns
module nand_async_bus_interface_test;
	import flash_host_pkg::*;
	logic SYS_CLK, RST_N, WR, RD, DQ_OE, rb_low;
	logic [7:0] ADDR;
	logic [31:0] WDATA, RDATA, v;
	logic [31:0] seed = 32'hAE7E;
	logic [15:0] DQ_OUT, dq_drv, w;
	logic [10:0] col;
	logic [16:0] row;
	ctl_pins_t CTL;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	wire [15:0] dq_wire = DQ_OE ? DQ_OUT : dq_drv;
	flash_host_ctrl #(.RESET_BUSY_CYC(200)) dut_u (.SYS_CLK(SYS_CLK),
		.RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .CTL(CTL), .DQ_IN(dq_wire), .DQ_OUT(DQ_OUT),
		.DQ_OE(DQ_OE), .RB_N_IN(~rb_low));
	flash_dev_model #(.BUSY_NS(1000)) mdl_u (.ctl(CTL), .dq(dq_wire),
		.dq_drv(dq_drv), .rb_low(rb_low));
	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Five address bytes, first cycle in the low byte
	function automatic logic [39:0] exp_addr(logic [10:0] c, logic [16:0] r);
		if (c[10]) c[9:5] = 5'h00;
		return {7'h00, r[16], r[15:0], 5'h00, c};
	endfunction : exp_addr
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask : rd
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd(OFS_STATUS);
			n++;
		end while (v[ST_BUSY_BIT] !== 1'b0 && n < 400);
		if (n >= 400) check(n, 0);
	endtask : wait_idle
	task automatic cmd(input logic [7:0] c);
		wr(OFS_CMD, c);
		wait_idle();
	endtask : cmd
	// Hang guard
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end
	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	initial begin
		RST_N = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 8'h00;
		WDATA = 32'h0;
		repeat (10) @(posedge SYS_CLK);
		check(CTL, CTL_RESET);
		check({DQ_OE, DQ_OUT}, 0);
		RST_N <= 1'b1;
		rd(8'hFC);
		check(v, 0);
		wr(OFS_CTRL, 32'h3);
		wait_idle();
		check({CTL.select_n, CTL.protect_n}, 2'b01);
		rd(OFS_CTRL);
		check(v, 3);
		cmd(CMD_READ_MODE);
		check(v[ST_ERR_BIT], 1);
		check(mdl_u.cmd_cnt, 0);
		wr(OFS_STATUS, 32'h8);
		cmd(CMD_RESET);
		check(v[ST_INIT_BIT], 1);
		check(v[ST_RDY_BIT], 1);
		check(mdl_u.cmd_reg, CMD_RESET);
		for (int i = 0; i < 4; i++) begin
			col = (i == 0) ? 11'h7FF : 11'(rnd());
			row = 17'(rnd());
			w = 16'(rnd());
			wr(OFS_COL, col);
			wr(OFS_ROW, row);
			rd(OFS_ROW);
			check(v, row);
			cmd(CMD_READ_MODE);
			wr(OFS_ADDR5, 0);
			wait_idle();
			check(mdl_u.addr_n, 5);
			check(mdl_u.addr_sh, exp_addr(col, row));
			check(mdl_u.plane, row[PLANE_BIT]);
			wr(OFS_DATA, w);
			wait_idle();
			check(mdl_u.din_reg, w);
			cmd(CMD_READ_MODE);
			wr(OFS_READ, 0);
			wait_idle();
			rd(OFS_DATA);
			check(v, w);
		end
		check(mdl_u.hi_bad, 0);
		cmd(CMD_STATUS_DIE);
		// Single address byte after 78h; junk in the upper bits must not leak
		col = 11'(rnd());
		wr(OFS_ADDR, {21'h1FFFFF, col});
		wait_idle();
		check(mdl_u.addr_n, 1);
		check(mdl_u.addr_sh[39:32], col[7:0]);
		check(mdl_u.hi_bad, 0);
		cmd(8'h90);
		wr(OFS_READ, 0);
		rd(OFS_STATUS);
		check(v[ST_ERR_BIT], 1);
		wr(OFS_STATUS, 32'h8);
		cmd(CMD_STATUS);
		wr(OFS_READ, 0);
		wait_idle();
		rd(OFS_DATA);
		check(v, 32'h00C0);
		cmd(CMD_READ_MODE);
		wr(OFS_READ, 0);
		wait_idle();
		check(v[ST_ERR_BIT], 0);
		rd(OFS_DATA);
		check(v, w);
		wr(OFS_CTRL, 32'h0);
		wait_idle();
		check({CTL.select_n, CTL.protect_n}, 2'b10);
		finish_test();
	end
endmodule : nand_async_bus_interface_test
